/* File: src/pgc_defs.svh */
// register offsets, widths and field positions for the port group pin control block
`ifndef PGC_DEFS_SVH
`define PGC_DEFS_SVH
`define PGC_OFF_DATA 12'h000
`define PGC_OFF_DATA_SR 12'h100
`define PGC_OFF_PIN_READ 12'h200
`define PGC_OFF_DIR 12'h300
`define PGC_OFF_MODE 12'h400
`define PGC_OFF_FSEL_LO 12'h500
`define PGC_OFF_FSEL_HI 12'h600
`define PGC_OFF_INVERT 12'h700
`define PGC_OFF_DIR_SR 12'h800
`define PGC_OFF_MODE_SR 12'h900
`define PGC_OFF_IBUF 12'hA00
`define PGC_OFF_BIDIR 12'hA10
`define PGC_OFF_DIRECT 12'hA20
`define PGC_OFF_ODRAIN 12'hA30
`define PGC_ADDR_W 12
`define PGC_EN_POS 16
`define PGC_RST_DIR 16'hFFFF
`define PGC_RST_ZERO 16'h0000
`endif

/* File: src/pgc_pkg.sv */
// types shared by the port group pin control block
package pgc_pkg;
	typedef enum logic [1:0] {
		PGC_PORT = 2'b00,
		PGC_ALT_SW = 2'b01,
		PGC_ALT_DIRECT = 2'b10
	} pgc_mode_t;
	// enable sits in the upper half so bit m is qualified by bit m+16
	typedef struct packed {
		logic [15:0] enable;
		logic [15:0] value;
	} pgc_sr_word_t;
endpackage : pgc_pkg

/* File: src/pgc_port_group.sv */
// port group pin control: apb register file, pin drive and read-back mux
//
// Contract
// - direct write replaces whole direction or mode-select register
// - direction set/reset: bit m takes value where bit m+16 enabled
// - mode-select set/reset: bit m takes value where bit m+16 enabled
// - set/reset changes only enabled bits, others stay unchanged
// - direct and set/reset paths usable interchangeably at any time
// - direct-control bit 1 in alternative mode: function drives enable, direction ignored
// - mode-select 0 is port mode, 1 is alternative mode
// - direction bit 1 is input, 0 is output
// - direct-control picks software or function direction in alternative mode
// - port mode drives pin from output data register bit
// - alternative mode drives pin from selected alternative function
// - port input reads data register if buffer off, pin if on
// - software alternative: read pin when input, function output when output
// - direct alternative: read function output when driving, pin when input
// - bidirectional-read bit forces pin level read in every mode
// - open-drain bit: 0 push-pull, 1 open-drain drive
// - direct write replaces whole output data register
// - output set/reset: bit m takes value where bit m+16 enabled
// - invert register: writing 1 toggles data bit, 0 leaves it
// - indirect data accesses alter only addressed bits, both paths usable
// - alternative output with bidirectional read feeds back to function input
// - two function-select bits choose one of four alternative functions
// - mode 1 and direct 1 is direct mode, direct 0 software mode
`timescale 1ns/100ps
`include "pgc_defs.svh"
module pgc_port_group #(
	parameter int PINS = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] alt_out_fn [4],
	input wire logic [PINS-1:0] alt_oe_fn [4],
	output logic [PINS-1:0] alt_in_fn [4]
);
	// ****************************************
	// register file
	// ****************************************
	logic [PINS-1:0] data_q;
	logic [PINS-1:0] dir_q;
	logic [PINS-1:0] mode_q;
	logic [PINS-1:0] fsel_lo_q;
	logic [PINS-1:0] fsel_hi_q;
	logic [PINS-1:0] ibuf_q;
	logic [PINS-1:0] bidir_q;
	logic [PINS-1:0] direct_q;
	logic [PINS-1:0] odrain_q;
	logic [`PGC_ADDR_W-1:0] addr;
	logic wr_en;
	logic rd_en;
	pgc_pkg::pgc_sr_word_t sr_word;

	assign addr = paddr[`PGC_ADDR_W-1:0];
	// single apb port: one access per cycle, so collisions are serialised
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;
	assign sr_word = pwdata;

	// applies a set/reset word, touching only enabled bits
	function automatic logic [PINS-1:0] apply_sr(input logic [PINS-1:0] cur,
		input pgc_pkg::pgc_sr_word_t w);
		logic [PINS-1:0] en;
		logic [PINS-1:0] val;
		en = w.enable[PINS-1:0];
		val = w.value[PINS-1:0];
		apply_sr = (cur & ~en) | (val & en);
	endfunction : apply_sr

	function automatic logic known_offset(input logic [`PGC_ADDR_W-1:0] a);
		case (a)
			`PGC_OFF_DATA, `PGC_OFF_DATA_SR, `PGC_OFF_PIN_READ, `PGC_OFF_DIR,
			`PGC_OFF_MODE, `PGC_OFF_FSEL_LO, `PGC_OFF_FSEL_HI, `PGC_OFF_INVERT,
			`PGC_OFF_DIR_SR, `PGC_OFF_MODE_SR, `PGC_OFF_IBUF, `PGC_OFF_BIDIR,
			`PGC_OFF_DIRECT, `PGC_OFF_ODRAIN: known_offset = 1'b1;
			default: known_offset = 1'b0;
		endcase
	endfunction : known_offset

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			dir_q <= PINS'(`PGC_RST_DIR);
		else if (wr_en && addr == `PGC_OFF_DIR)
			dir_q <= pwdata[PINS-1:0];
		else if (wr_en && addr == `PGC_OFF_DIR_SR)
			dir_q <= apply_sr(dir_q, sr_word);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mode_q <= PINS'(`PGC_RST_ZERO);
		else if (wr_en && addr == `PGC_OFF_MODE)
			mode_q <= pwdata[PINS-1:0];
		else if (wr_en && addr == `PGC_OFF_MODE_SR)
			mode_q <= apply_sr(mode_q, sr_word);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			data_q <= PINS'(`PGC_RST_ZERO);
		else if (wr_en && addr == `PGC_OFF_DATA)
			data_q <= pwdata[PINS-1:0];
		else if (wr_en && addr == `PGC_OFF_DATA_SR)
			data_q <= apply_sr(data_q, sr_word);
		else if (wr_en && addr == `PGC_OFF_INVERT)
			data_q <= data_q ^ pwdata[PINS-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fsel_lo_q <= PINS'(`PGC_RST_ZERO);
			fsel_hi_q <= PINS'(`PGC_RST_ZERO);
			ibuf_q <= PINS'(`PGC_RST_ZERO);
			bidir_q <= PINS'(`PGC_RST_ZERO);
			direct_q <= PINS'(`PGC_RST_ZERO);
			odrain_q <= PINS'(`PGC_RST_ZERO);
		end
		else if (wr_en)
		begin
			case (addr)
				`PGC_OFF_FSEL_LO: fsel_lo_q <= pwdata[PINS-1:0];
				`PGC_OFF_FSEL_HI: fsel_hi_q <= pwdata[PINS-1:0];
				`PGC_OFF_IBUF: ibuf_q <= pwdata[PINS-1:0];
				`PGC_OFF_BIDIR: bidir_q <= pwdata[PINS-1:0];
				`PGC_OFF_DIRECT: direct_q <= pwdata[PINS-1:0];
				`PGC_OFF_ODRAIN: odrain_q <= pwdata[PINS-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// per-pin drive and read-back
	// ****************************************
	logic [PINS-1:0] alt_o;
	logic [PINS-1:0] alt_oe;
	logic [PINS-1:0] drive_en;
	logic [PINS-1:0] drive_val;
	logic [PINS-1:0] read_val;
	logic [PINS-1:0] fb_en;

	always_comb
	begin
		for (int m = 0; m < PINS; m++)
		begin
			logic [1:0] fs;
			pgc_pkg::pgc_mode_t md;
			fs = {fsel_hi_q[m], fsel_lo_q[m]};
			alt_o[m] = alt_out_fn[fs][m];
			alt_oe[m] = alt_oe_fn[fs][m];
			if (!mode_q[m])
				md = pgc_pkg::PGC_PORT;
			else if (direct_q[m])
				md = pgc_pkg::PGC_ALT_DIRECT;
			else
				md = pgc_pkg::PGC_ALT_SW;
			case (md)
				pgc_pkg::PGC_PORT:
				begin
					drive_en[m] = !dir_q[m];
					drive_val[m] = data_q[m];
					read_val[m] = dir_q[m] ? (ibuf_q[m] ? pin_in[m] : data_q[m])
						: data_q[m];
				end
				pgc_pkg::PGC_ALT_SW:
				begin
					drive_en[m] = !dir_q[m];
					drive_val[m] = alt_o[m];
					read_val[m] = dir_q[m] ? pin_in[m] : alt_o[m];
				end
				pgc_pkg::PGC_ALT_DIRECT:
				begin
					drive_en[m] = alt_oe[m];
					drive_val[m] = alt_o[m];
					read_val[m] = alt_oe[m] ? alt_o[m] : pin_in[m];
				end
				default:
				begin
					drive_en[m] = 1'b0;
					drive_val[m] = 1'b0;
					read_val[m] = 1'b0;
				end
			endcase
			if (bidir_q[m])
				read_val[m] = pin_in[m];
			fb_en[m] = mode_q[m] && drive_en[m] && bidir_q[m];
		end
	end

	// outputs registered: one cycle of latency from control change to pin
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_out <= PINS'(`PGC_RST_ZERO);
			pin_oe <= PINS'(`PGC_RST_ZERO);
		end
		else
		begin
			// open drain only ever drives low, a high releases the pin
			pin_out <= drive_val & ~odrain_q;
			pin_oe <= drive_en & ~(odrain_q & drive_val);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < 4; k++)
				alt_in_fn[k] <= PINS'(`PGC_RST_ZERO);
		end
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				for (int m = 0; m < PINS; m++)
				begin
					// only the selected function sees the pin; others read zero
					if ({fsel_hi_q[m], fsel_lo_q[m]} != 2'(k))
						alt_in_fn[k][m] <= 1'b0;
					else if (fb_en[m])
						alt_in_fn[k][m] <= drive_val[m];
					else
						alt_in_fn[k][m] <= pin_in[m];
				end
			end
		end
	end

	// ****************************************
	// apb answer
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pslverr <= 1'b0;
		else
			pslverr <= psel && !penable && !known_offset(addr);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (rd_en)
		begin
			prdata <= 32'h0000_0000;
			case (addr)
				`PGC_OFF_DATA: prdata[PINS-1:0] <= data_q;
				`PGC_OFF_PIN_READ: prdata[PINS-1:0] <= read_val;
				`PGC_OFF_DIR: prdata[PINS-1:0] <= dir_q;
				`PGC_OFF_MODE: prdata[PINS-1:0] <= mode_q;
				`PGC_OFF_FSEL_LO: prdata[PINS-1:0] <= fsel_lo_q;
				`PGC_OFF_FSEL_HI: prdata[PINS-1:0] <= fsel_hi_q;
				`PGC_OFF_IBUF: prdata[PINS-1:0] <= ibuf_q;
				`PGC_OFF_BIDIR: prdata[PINS-1:0] <= bidir_q;
				`PGC_OFF_DIRECT: prdata[PINS-1:0] <= direct_q;
				`PGC_OFF_ODRAIN: prdata[PINS-1:0] <= odrain_q;
				default: ; // set/reset and invert registers read zero
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_dir_sr_bits: assert property (wr_en && addr == `PGC_OFF_DIR_SR |=>
		dir_q == apply_sr($past(dir_q), $past(sr_word)))
		else $error("direction set/reset wrong");
	a_mode_direct_wr: assert property (wr_en && addr == `PGC_OFF_MODE |=>
		mode_q == $past(pwdata[PINS-1:0]))
		else $error("mode direct write wrong");
	a_mode_sr_bits: assert property (wr_en && addr == `PGC_OFF_MODE_SR |=>
		(mode_q & ~$past(sr_word.enable[PINS-1:0])) ==
		($past(mode_q) & ~$past(sr_word.enable[PINS-1:0])))
		else $error("mode set/reset touched other bits");
	a_data_invert: assert property (wr_en && addr == `PGC_OFF_INVERT |=>
		data_q == ($past(data_q) ^ $past(pwdata[PINS-1:0])))
		else $error("invert wrong");
	a_data_sr_bits: assert property (wr_en && addr == `PGC_OFF_DATA_SR |=>
		data_q == apply_sr($past(data_q), $past(sr_word)))
		else $error("data set/reset wrong");
	a_bidir_read: assert property (rd_en && addr == `PGC_OFF_PIN_READ |=>
		((prdata[PINS-1:0] ^ $past(pin_in)) & $past(bidir_q)) == '0)
		else $error("bidirectional read not pin level");
	a_port_drive: assert property ((~mode_q & ~dir_q & ~odrain_q) != '0 |=>
		((pin_out ^ $past(data_q)) & $past(~mode_q & ~dir_q & ~odrain_q)) == '0)
		else $error("port output not from data register");
	a_sr_reads_zero: assert property (rd_en && (addr == `PGC_OFF_DIR_SR ||
		addr == `PGC_OFF_INVERT) |=> prdata == 32'h0000_0000)
		else $error("set/reset register read nonzero");
	a_direct_oe: assert property (1'b1 |=>
		((pin_oe & ~$past(alt_oe_fn[0] | alt_oe_fn[1] | alt_oe_fn[2] | alt_oe_fn[3]))
		& $past(mode_q & direct_q)) == '0)
		else $error("direct mode drove without function enable");
	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	c_dir_sr: cover property (wr_en && addr == `PGC_OFF_DIR_SR);
	c_invert: cover property (wr_en && addr == `PGC_OFF_INVERT);
	c_direct_mode: cover property ((mode_q & direct_q) != '0);
	c_feedback: cover property (fb_en != '0);
endmodule : pgc_port_group

/* File: dv/pgc_pin_model.sv */
// pin wiring and alternative function model facing the port group
`timescale 1ns/100ps
module pgc_pin_model (
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] ext_lvl,
	output logic [15:0] pin_in,
	output logic [15:0] alt_out_fn [4],
	output logic [15:0] alt_oe_fn [4]
);
	// undriven pins follow the outside level; open drain can only pull low
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	always_comb
	begin
		for (int k = 0; k < 4; k++)
		begin
			alt_out_fn[k] = 16'h1111 << k;
			// functions drive the low byte only, so direct mode is visible
			alt_oe_fn[k] = 16'h00FF;
		end
	end
endmodule : pgc_pin_model

/* File: dv/port_group_pin_control_bench.sv */
// self-checking bench for the port group pin control block
`timescale 1ns/100ps
`include "pgc_defs.svh"
module port_group_pin_control_bench;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [15:0] pin_in, pin_out, pin_oe;
	logic [15:0] alt_out_fn [4];
	logic [15:0] alt_oe_fn [4];
	logic [15:0] alt_in_fn [4];
	logic [15:0] ext_lvl;
	int failures, total_checks;
	pgc_port_group #(.PINS(16)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .alt_out_fn(alt_out_fn),
		.alt_oe_fn(alt_oe_fn), .alt_in_fn(alt_in_fn));
	pgc_pin_model model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
		.pin_in(pin_in), .alt_out_fn(alt_out_fn), .alt_oe_fn(alt_oe_fn));
	always #12.5 clk_sys = ~clk_sys;
	// ********************
	// bus and compare tasks
	// ********************
	task automatic give_verdict;
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask : cmp
	// request held until the edge that samples pready high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {20'h0, a};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		// pready, prdata and pslverr are taken as they stand at the rising edge
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (pready === 1'h1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20)
			cmp("pready", 32'h1, 32'h0);
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		bus(1'h1, a, d, r, e);
	endtask : wr
	task automatic chk(input string nm, input logic [11:0] a, input logic [31:0] ex);
		logic [31:0] r;
		logic e;
		bus(1'h0, a, 32'h0, r, e);
		cmp(nm, ex, r);
	endtask : chk
	task automatic settle;
		repeat (3) @(negedge clk_sys);
	endtask : settle
	// ********************
	// scenarios
	// ********************
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		chk("dir", `PGC_OFF_DIR, 32'h0000FFFF);
		chk("mode", `PGC_OFF_MODE, 32'h0);
		chk("data", `PGC_OFF_DATA, 32'h0);
		cmp("pin_oe", 32'h0, pin_oe);
		bus(1'h0, 12'hB00, 32'h0, r, e);
		cmp("unmapped err", 32'h1, e);
		cmp("unmapped data", 32'h0, r);
	endtask : t_reset
	task automatic t_ctrl;
		wr(`PGC_OFF_DIR, 32'h0000A5A5);
		chk("dir", `PGC_OFF_DIR, 32'h0000A5A5);
		wr(`PGC_OFF_DIR_SR, 32'h00F00030);
		chk("dir", `PGC_OFF_DIR, 32'h0000A535);
		chk("dir sr", `PGC_OFF_DIR_SR, 32'h0);
		wr(`PGC_OFF_MODE, 32'h00001234);
		wr(`PGC_OFF_MODE_SR, 32'h000F0005);
		chk("mode", `PGC_OFF_MODE, 32'h00001235);
		chk("mode sr", `PGC_OFF_MODE_SR, 32'h0);
	endtask : t_ctrl
	task automatic t_data;
		wr(`PGC_OFF_DATA, 32'h000000FF);
		chk("data", `PGC_OFF_DATA, 32'h000000FF);
		wr(`PGC_OFF_DATA_SR, 32'h0F0F0A0A);
		chk("data", `PGC_OFF_DATA, 32'h00000AFA);
		wr(`PGC_OFF_INVERT, 32'h00001001);
		chk("data", `PGC_OFF_DATA, 32'h00001AFB);
	endtask : t_data
	task automatic t_port;
		wr(`PGC_OFF_MODE, 32'h0);
		wr(`PGC_OFF_DIR, 32'h0);
		settle;
		cmp("pin_out", 32'h1AFB, pin_out);
		cmp("pin_oe", 32'hFFFF, pin_oe);
		chk("pin read", `PGC_OFF_PIN_READ, 32'h1AFB);
		wr(`PGC_OFF_DIR, 32'hFFFF);
		settle;
		cmp("pin_oe", 32'h0, pin_oe);
		chk("pin read", `PGC_OFF_PIN_READ, 32'h1AFB);
		wr(`PGC_OFF_IBUF, 32'hFFFF);
		chk("pin read", `PGC_OFF_PIN_READ, 32'h3C3C);
	endtask : t_port
	task automatic t_alt;
		logic [15:0] p;
		wr(`PGC_OFF_MODE, 32'hFFFF);
		wr(`PGC_OFF_DIR, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			p = 16'h1111 << k;
			wr(`PGC_OFF_FSEL_LO, k[0] ? 32'hFFFF : 32'h0);
			wr(`PGC_OFF_FSEL_HI, k[1] ? 32'hFFFF : 32'h0);
			settle;
			cmp("pin_out", p, pin_out);
			chk("pin read", `PGC_OFF_PIN_READ, p);
			wr(`PGC_OFF_DIR_SR, 32'hFFFFFFFF);
			settle;
			chk("pin read", `PGC_OFF_PIN_READ, 32'h3C3C);
			cmp("alt_in", 32'h3C3C, alt_in_fn[k]);
			cmp("alt_in other", 32'h0, alt_in_fn[(k + 1) % 4]);
			wr(`PGC_OFF_DIR_SR, 32'hFFFF0000);
		end
		wr(`PGC_OFF_DIRECT, 32'hFFFF);
		settle;
		cmp("pin_oe", 32'h00FF, pin_oe);
		chk("pin read", `PGC_OFF_PIN_READ, 32'h3C88);
		wr(`PGC_OFF_DIRECT, 32'h0);
		wr(`PGC_OFF_BIDIR, 32'hFFFF);
		settle;
		cmp("alt_in", 32'h8888, alt_in_fn[3]);
		wr(`PGC_OFF_ODRAIN, 32'hFFFF);
		settle;
		cmp("pin_out", 32'h0, pin_out);
		cmp("pin_oe", 32'h7777, pin_oe);
		chk("pin read", `PGC_OFF_PIN_READ, 32'h0808);
	endtask : t_alt
	initial
	begin
		#400000;
		failures++;
		give_verdict;
	end
	initial
	begin
		clk_sys = 1'h0;
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		ext_lvl = 16'h3C3C;
		failures = 0;
		total_checks = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'h1;
		t_reset;
		t_ctrl;
		t_data;
		t_port;
		t_alt;
		give_verdict;
	end
endmodule : port_group_pin_control_bench
